// ### pltsup_panel_model.sv
// Operator panel stand-in that sends one good-telegram pulse per period
module pltsup_panel_model #(
  parameter int PERIOD = 6
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control and telegram pulse
  input  wire logic en,
  output logic      telegram_ok
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt;

  // Silent while disabled, so the bench can starve the link on purpose
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      telegram_ok <= 1'b0;
    end else begin
      cnt <= (en && cnt < PERIOD - 1) ? cnt + 1 : 0;
      telegram_ok <= en && cnt == PERIOD - 1;
    end
  end
endmodule

// ### pltsup_params.svh
// Register offsets, field positions, reset values and timing counts of the panel link supervisor
`ifndef PLTSUP_PARAMS_SVH
`define PLTSUP_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PLT_OFS_CTRL      8'h00
`define PLT_OFS_LIMIT     8'h04
`define PLT_OFS_PANEL     8'h08
`define PLT_OFS_PWD       8'h0C
`define PLT_OFS_UNLOCK    8'h10
`define PLT_OFS_STATUS    8'h14
`define PLT_OFS_IRQ_STAT  8'h18
`define PLT_OFS_IRQ_MASK  8'h1C
`define PLT_OFS_COUNT     8'h20

// ****************************************************************
// Reset values and ranges
// ****************************************************************
`define PLT_MODE_RST      2'h2
`define PLT_ACTION_RST    3'h1
`define PLT_LIMIT_RST     10'h003
`define PLT_LIMIT_MIN     10'h001
`define PLT_LIMIT_MAX     10'h3E7
`define PLT_BACKL_RST     4'hA
`define PLT_BACKL_MIN     4'h1
`define PLT_WEEKDAY_RST   3'h0
`define PLT_WEEKDAY_MAX   3'h6
`define PLT_PWD_RST       14'h0000
`define PLT_PWD_MAX       14'h270F
`define PLT_PWOPT_RST     2'h1

// ****************************************************************
// Field positions
// ****************************************************************
`define PLT_CTRL_MODE_LSB   0
`define PLT_CTRL_ACT_LSB    4
`define PLT_PANEL_BL_LSB    0
`define PLT_PANEL_WD_LSB    8
`define PLT_PANEL_PO_LSB    12
`define PLT_IRQ_TIMEOUT     0
`define PLT_IRQ_PWCHG       1
`define PLT_IRQ_RECOVER     2

// ****************************************************************
// Timing
// ****************************************************************
`define PLT_CLK_HZ        100000000
`define PLT_SECOND_NS     1000000000
`define PLT_CLK_NS        10
`define PLT_SEC_CYCLES    (`PLT_SECOND_NS / `PLT_CLK_NS)

`endif

// ### pltsup_pkg.sv
// Types shared by the panel link supervisor
package pltsup_pkg;
  typedef enum logic [1:0] {
    PLT_MODE_OFF   = 2'h0,
    PLT_MODE_FAULT = 2'h1,
    PLT_MODE_ALARM = 2'h2
  } pltsup_mode_e;

  typedef enum logic [2:0] {
    PLT_ACT_INDICATE = 3'h0,
    PLT_ACT_RAMP     = 3'h1,
    PLT_ACT_DISABLE  = 3'h2,
    PLT_ACT_LOCAL    = 3'h3,
    PLT_ACT_REMOTE   = 3'h4
  } pltsup_action_e;

  typedef enum logic [1:0] {
    PLT_PWOPT_OFF    = 2'h0,
    PLT_PWOPT_ON     = 2'h1,
    PLT_PWOPT_CHANGE = 2'h2
  } pltsup_pwopt_e;
endpackage

// ### pltsup_tick.sv
// Divider that gives a one-cycle pulse every DIV clock cycles
module pltsup_tick #(
  parameter int DIV = 100000000
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Restart and output pulse
  input  wire logic restart,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  // Refused at elaboration: a divide by one leaves no count between pulses
  if (DIV < 2) begin : g_div_check
    $error("DIV must be at least 2");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q + W'(1);
    if (restart || cnt_q == W'(DIV - 1)) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = !restart && cnt_q == W'(DIV - 1);
endmodule

// ### pltsup_top.sv
// Panel link timeout supervisor with panel settings behind an AHB-Lite slave
//
// Notes on behaviour
// - Mode 0 off, 1 fault, 2 alarm; default 2
// - Alarm mode raises alarm and selected action in the same cycle
// - Action 0 indicates only; action default 1
// - Action 1 issues ramp stop command
// - Action 2 asserts general disable, motor coasts
// - Action 3 switches command source to local
// - Action 4 switches command source to remote
// - Timeout after limit seconds silent, 1..999, default 3
// - Backlight level 1..15, default 10
// - Weekday 0 Sunday to 6 Saturday, default 0
// - Password 0..9999, default 0, gates configuration
// - Password option 0 off, 1 on, 2 change
// - Option 2 opens new-password entry dialog
`include "pltsup_params.svh"
module pltsup_top
  import pltsup_pkg::*;
#(
  parameter int SEC_CYCLES = `PLT_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Panel link and motor state
  input  wire logic        telegram_ok,
  input  wire logic        motor_running,
  // Actions toward sequencer and fault logic
  output logic             panel_timeout_fault_code,
  output logic             panel_timeout_alarm_code,
  output logic             ramp_stop_cmd,
  output logic             general_disable,
  output logic             local_command_source,
  output logic             remote_command_source,
  // Panel settings
  output logic [3:0]       backlight_level_setting,
  output logic [2:0]       weekday_setting,
  output logic             password_dialog,
  output logic             config_unlocked,
  // Interrupt
  output logic             irq
);
  // ****************************************************************
  // Bus address phase capture
  // ****************************************************************
  logic       wr_pend_q, wr_pend_d;
  logic       rd_pend_q, rd_pend_d;
  logic [7:0] addr_q, addr_d;
  logic       take;

  assign take = hsel && hready && htrans[1] && hsize == 3'h2;

  always_comb begin
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    addr_d    = addr_q;
    if (hready) begin
      wr_pend_d = take && hwrite;
      rd_pend_d = take && !hwrite;
      if (take) begin
        addr_d = haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q    <= addr_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // Settings registers
  // ****************************************************************
  pltsup_mode_e   mode_q, mode_d;
  pltsup_action_e action_q, action_d;
  logic [9:0]     limit_q, limit_d;
  logic [3:0]     backl_q, backl_d;
  logic [2:0]     wday_q, wday_d;
  logic [13:0]    pwd_q, pwd_d;
  pltsup_pwopt_e  pwopt_q, pwopt_d;
  logic           unlock_q, unlock_d;
  logic [2:0]     ist_q, ist_d;
  logic [2:0]     imask_q, imask_d;
  logic           wr_ok;
  logic           wr_cfg;
  logic           pwchg_ev;

  logic [1:0]  w_mode;
  logic [2:0]  w_act;
  logic [9:0]  w_lim;
  logic [3:0]  w_bl;
  logic [2:0]  w_wd;
  logic [1:0]  w_po;
  logic [13:0] w_pw;

  assign w_mode = hwdata[`PLT_CTRL_MODE_LSB +: 2];
  assign w_act  = hwdata[`PLT_CTRL_ACT_LSB +: 3];
  assign w_lim  = hwdata[9:0];
  assign w_bl   = hwdata[`PLT_PANEL_BL_LSB +: 4];
  assign w_wd   = hwdata[`PLT_PANEL_WD_LSB +: 3];
  assign w_po   = hwdata[`PLT_PANEL_PO_LSB +: 2];
  assign w_pw   = hwdata[13:0];

  // Config writes need protection off or a matching password entry
  assign wr_ok  = wr_pend_q;
  assign wr_cfg = wr_ok && (pwopt_q == PLT_PWOPT_OFF || unlock_q);

  logic timeout_ev;
  logic recover_ev;

  always_comb begin
    mode_d   = mode_q;
    action_d = action_q;
    limit_d  = limit_q;
    backl_d  = backl_q;
    wday_d   = wday_q;
    pwd_d    = pwd_q;
    pwopt_d  = pwopt_q;
    unlock_d = unlock_q;
    imask_d  = imask_q;
    pwchg_ev = 1'b0;
    if (wr_cfg && addr_q == `PLT_OFS_CTRL && !motor_running) begin
      if (w_mode <= 2'h2) begin
        mode_d = pltsup_mode_e'(w_mode);
      end
      if (w_act <= 3'h4) begin
        action_d = pltsup_action_e'(w_act);
      end
    end
    if (wr_cfg && addr_q == `PLT_OFS_LIMIT &&
        w_lim >= `PLT_LIMIT_MIN && w_lim <= `PLT_LIMIT_MAX) begin
      limit_d = w_lim;
    end
    if (wr_cfg && addr_q == `PLT_OFS_PANEL) begin
      if (w_bl >= `PLT_BACKL_MIN) begin
        backl_d = w_bl;
      end
      if (w_wd <= `PLT_WEEKDAY_MAX) begin
        wday_d = w_wd;
      end
      if (w_po <= 2'h2) begin
        pwopt_d = pltsup_pwopt_e'(w_po);
      end
    end
    // New password taken only while the change dialog is open
    if (wr_cfg && addr_q == `PLT_OFS_PWD && pwopt_q == PLT_PWOPT_CHANGE &&
        w_pw <= `PLT_PWD_MAX) begin
      pwd_d    = w_pw;
      pwopt_d  = PLT_PWOPT_ON;
      pwchg_ev = 1'b1;
    end
    // Entry register: match unlocks, anything else locks again
    if (wr_ok && addr_q == `PLT_OFS_UNLOCK) begin
      unlock_d = (w_pw == pwd_q);
    end
    if (wr_ok && addr_q == `PLT_OFS_IRQ_MASK) begin
      imask_d = hwdata[2:0];
    end
    // Hardware set wins over write-one-to-clear
    ist_d = ist_q;
    if (wr_ok && addr_q == `PLT_OFS_IRQ_STAT) begin
      ist_d = ist_q & ~hwdata[2:0];
    end
    ist_d[`PLT_IRQ_TIMEOUT] = ist_d[`PLT_IRQ_TIMEOUT] | timeout_ev;
    ist_d[`PLT_IRQ_PWCHG]   = ist_d[`PLT_IRQ_PWCHG] | pwchg_ev;
    ist_d[`PLT_IRQ_RECOVER] = ist_d[`PLT_IRQ_RECOVER] | recover_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q   <= pltsup_mode_e'(`PLT_MODE_RST);
      action_q <= pltsup_action_e'(`PLT_ACTION_RST);
      limit_q  <= `PLT_LIMIT_RST;
      backl_q  <= `PLT_BACKL_RST;
      wday_q   <= `PLT_WEEKDAY_RST;
      pwd_q    <= `PLT_PWD_RST;
      pwopt_q  <= pltsup_pwopt_e'(`PLT_PWOPT_RST);
      unlock_q <= 1'b0;
      ist_q    <= 3'h0;
      imask_q  <= 3'h0;
    end else begin
      mode_q   <= mode_d;
      action_q <= action_d;
      limit_q  <= limit_d;
      backl_q  <= backl_d;
      wday_q   <= wday_d;
      pwd_q    <= pwd_d;
      pwopt_q  <= pwopt_d;
      unlock_q <= unlock_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
    end
  end

  // ****************************************************************
  // Timeout counter
  // ****************************************************************
  logic       sec_tick;
  logic [9:0] secs_q, secs_d;
  logic       tout_q, tout_d;

  pltsup_tick #(
    .DIV (SEC_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .restart (telegram_ok),
    .tick    (sec_tick)
  );

  // Counting stops at the limit so the event cannot repeat until a telegram
  always_comb begin
    secs_d     = secs_q;
    tout_d     = tout_q;
    timeout_ev = 1'b0;
    recover_ev = 1'b0;
    if (telegram_ok) begin
      secs_d     = 10'h000;
      tout_d     = 1'b0;
      recover_ev = tout_q;
    end else if (sec_tick && !tout_q) begin
      secs_d = secs_q + 10'h001;
      if (secs_d >= limit_q) begin
        tout_d     = 1'b1;
        timeout_ev = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secs_q <= 10'h000;
      tout_q <= 1'b0;
    end else begin
      secs_q <= secs_d;
      tout_q <= tout_d;
    end
  end

  // ****************************************************************
  // Action decode
  // ****************************************************************
  logic alarm_on;
  logic fault_q, alarm_q, ramp_q, dis_q, loc_q, rem_q;

  assign alarm_on = tout_q && mode_q == PLT_MODE_ALARM;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 1'b0;
      alarm_q <= 1'b0;
      ramp_q  <= 1'b0;
      dis_q   <= 1'b0;
      loc_q   <= 1'b0;
      rem_q   <= 1'b0;
    end else begin
      fault_q <= tout_q && mode_q == PLT_MODE_FAULT;
      alarm_q <= alarm_on;
      ramp_q  <= alarm_on && action_q == PLT_ACT_RAMP;
      dis_q   <= alarm_on && action_q == PLT_ACT_DISABLE;
      loc_q   <= alarm_on && action_q == PLT_ACT_LOCAL;
      rem_q   <= alarm_on && action_q == PLT_ACT_REMOTE;
    end
  end

  assign panel_timeout_fault_code = fault_q;
  assign panel_timeout_alarm_code = alarm_q;
  assign ramp_stop_cmd            = ramp_q;
  assign general_disable          = dis_q;
  assign local_command_source     = loc_q;
  assign remote_command_source    = rem_q;
  assign backlight_level_setting  = backl_q;
  assign weekday_setting          = wday_q;
  assign password_dialog          = pwopt_q == PLT_PWOPT_CHANGE;
  assign config_unlocked          = pwopt_q == PLT_PWOPT_OFF || unlock_q;
  assign irq                      = |(ist_q & imask_q);

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (take && !hwrite) begin
      case (haddr)
        `PLT_OFS_CTRL:     rdata_d = {25'h0, action_q, 2'h0, mode_q};
        `PLT_OFS_LIMIT:    rdata_d = {22'h0, limit_q};
        `PLT_OFS_PANEL:    rdata_d = {18'h0, pwopt_q, 1'b0, wday_q, 4'h0, backl_q};
        `PLT_OFS_UNLOCK:   rdata_d = {31'h0, unlock_q};
        `PLT_OFS_STATUS:   rdata_d = {26'h0, rem_q, loc_q, dis_q, ramp_q, alarm_q, fault_q};
        `PLT_OFS_IRQ_STAT: rdata_d = {29'h0, ist_q};
        `PLT_OFS_IRQ_MASK: rdata_d = {29'h0, imask_q};
        `PLT_OFS_COUNT:    rdata_d = {21'h0, tout_q, secs_q};
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_tel_then_quiet;
    telegram_ok ##1 !telegram_ok;
  endsequence

  fault_follows_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tout_q && mode_q == PLT_MODE_FAULT) |=> fault_q)
    else $error("fault not raised in fault mode");
  alarm_needs_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    alarm_q |-> $past(mode_q) == PLT_MODE_ALARM && $past(tout_q))
    else $error("alarm without alarm mode");
  indicate_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(action_q) == PLT_ACT_INDICATE) |-> !(ramp_q || dis_q || loc_q || rem_q))
    else $error("action taken in indicate-only");
  ramp_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ramp_q |-> alarm_q && $past(action_q) == PLT_ACT_RAMP)
    else $error("ramp stop without cause");
  disable_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dis_q |-> alarm_q && !ramp_q)
    else $error("general disable without alarm");
  source_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(loc_q && rem_q))
    else $error("local and remote together");
  remote_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rem_q |-> $past(action_q) == PLT_ACT_REMOTE)
    else $error("remote without action 4");
  limit_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    limit_q >= `PLT_LIMIT_MIN && limit_q <= `PLT_LIMIT_MAX)
    else $error("timeout limit out of range");
  tel_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_tel_then_quiet |-> secs_q == 10'h000 && !tout_q)
    else $error("telegram did not restart counter");
  event_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timeout_ev |=> !timeout_ev until telegram_ok)
    else $error("timeout event repeated");
  stopped_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    motor_running |=> $stable(mode_q) && $stable(action_q))
    else $error("mode changed while running");
  backl_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    backl_q >= `PLT_BACKL_MIN && wday_q <= `PLT_WEEKDAY_MAX)
    else $error("panel setting out of range");
  pwd_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(pwd_q) |-> $past(pwopt_q) == PLT_PWOPT_CHANGE && pwd_q <= `PLT_PWD_MAX)
    else $error("password changed outside dialog");
  pwopt_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pwopt_q != 2'h3)
    else $error("bad password option");
endmodule

// ### test_panel_link_timeout_supervisor.sv
// Self-checking bench for the panel link timeout supervisor
`include "pltsup_params.svh"
module test_panel_link_timeout_supervisor
  import pltsup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  // Short second keeps the run brief; all timing expectations scale with it
  localparam int SEC = 20;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        motor_running = 1'b0;
  logic        panel_en = 1'b1;
  logic [31:0] hrdata, tmp;
  logic        hready, hreadyout, hresp, telegram_ok, irq;
  logic        panel_timeout_fault_code, panel_timeout_alarm_code, ramp_stop_cmd;
  logic        general_disable, local_command_source, remote_command_source;
  logic        password_dialog, config_unlocked;
  logic [3:0]  backlight_level_setting;
  logic [2:0]  weekday_setting;
  logic [5:0]  acts;
  int          fails = 0;
  int          checks = 0;

  assign hready = hreadyout;
  assign acts = {remote_command_source, local_command_source, general_disable,
                 ramp_stop_cmd, panel_timeout_alarm_code, panel_timeout_fault_code};

  always #5 hclk = ~hclk;

  pltsup_top #(.SEC_CYCLES(SEC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .telegram_ok(telegram_ok), .motor_running(motor_running),
    .panel_timeout_fault_code(panel_timeout_fault_code),
    .panel_timeout_alarm_code(panel_timeout_alarm_code),
    .ramp_stop_cmd(ramp_stop_cmd), .general_disable(general_disable),
    .local_command_source(local_command_source),
    .remote_command_source(remote_command_source),
    .backlight_level_setting(backlight_level_setting),
    .weekday_setting(weekday_setting), .password_dialog(password_dialog),
    .config_unlocked(config_unlocked), .irq(irq));

  pltsup_panel_model #(.PERIOD(SEC / 3)) panel (
    .hclk(hclk), .hresetn(hresetn), .en(panel_en), .telegram_ok(telegram_ok));

  // ****************************************************************
  // Tables
  // ****************************************************************
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } pltsup_reg_s;
  pltsup_reg_s reg_rows [14] = '{
    '{`PLT_OFS_CTRL, 32'h0000_0000, 32'h0000_0000},
    '{`PLT_OFS_CTRL, 32'h0000_0003, 32'h0000_0000},
    '{`PLT_OFS_CTRL, 32'h0000_0050, 32'h0000_0000},
    '{`PLT_OFS_CTRL, 32'h0000_0042, 32'h0000_0042},
    '{`PLT_OFS_LIMIT, 32'h0000_0000, 32'h0000_0003},
    '{`PLT_OFS_LIMIT, 32'h0000_03E8, 32'h0000_0003},
    '{`PLT_OFS_LIMIT, 32'h0000_03E7, 32'h0000_03E7},
    '{`PLT_OFS_LIMIT, 32'h0000_0001, 32'h0000_0001},
    '{`PLT_OFS_LIMIT, 32'h0000_0002, 32'h0000_0002},
    '{`PLT_OFS_PANEL, 32'h0000_000F, 32'h0000_000F},
    '{`PLT_OFS_PANEL, 32'h0000_3700, 32'h0000_000F},
    '{`PLT_OFS_PANEL, 32'h0000_0601, 32'h0000_0601},
    '{`PLT_OFS_PWD, 32'h0000_0005, 32'h0000_0000},
    '{8'h24, 32'hFFFF_FFFF, 32'h0000_0000}};

  // Expected outputs in status order {rem,loc,dis,ramp,alarm,fault}
  typedef struct {
    pltsup_mode_e   mode;
    pltsup_action_e act;
    logic [5:0]     e;
  } pltsup_act_s;
  pltsup_act_s act_rows [7] = '{
    '{PLT_MODE_OFF, PLT_ACT_RAMP, 6'h00},
    '{PLT_MODE_FAULT, PLT_ACT_DISABLE, 6'h01},
    '{PLT_MODE_ALARM, PLT_ACT_INDICATE, 6'h02},
    '{PLT_MODE_ALARM, PLT_ACT_RAMP, 6'h06},
    '{PLT_MODE_ALARM, PLT_ACT_DISABLE, 6'h0A},
    '{PLT_MODE_ALARM, PLT_ACT_LOCAL, 6'h12},
    '{PLT_MODE_ALARM, PLT_ACT_REMOTE, 6'h22}};

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One single word transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, tmp);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, tmp);
    check(tmp, e);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'(backlight_level_setting), 32'(`PLT_BACKL_RST));
    check(32'(weekday_setting), 32'(`PLT_WEEKDAY_RST));
    check(32'({password_dialog, config_unlocked, irq, hresp}), 32'h0);
    rdc(`PLT_OFS_CTRL, 32'h0000_0012);
    rdc(`PLT_OFS_LIMIT, 32'h0000_0003);
    rdc(`PLT_OFS_PANEL, 32'h0000_100A);
    wr(`PLT_OFS_LIMIT, 32'h0000_0001);
    rdc(`PLT_OFS_LIMIT, 32'h0000_0003);
    wr(`PLT_OFS_UNLOCK, 32'h0000_0000);
    rdc(`PLT_OFS_UNLOCK, 32'h0000_0001);
    foreach (reg_rows[i]) begin
      wr(reg_rows[i].a, reg_rows[i].d);
      rdc(reg_rows[i].a, reg_rows[i].e);
    end
    check(32'(backlight_level_setting), 32'h1);
    check(32'(weekday_setting), 32'h6);
    wr(`PLT_OFS_PANEL, 32'h0000_2601);
    repeat (2) @(posedge hclk);
    check(32'(password_dialog), 32'h1);
    rdc(`PLT_OFS_PANEL, 32'h0000_2601);
    wr(`PLT_OFS_PWD, 32'h0000_270F);
    rdc(`PLT_OFS_PANEL, 32'h0000_1601);
    check(32'({password_dialog, irq}), 32'h0);
    rdc(`PLT_OFS_IRQ_STAT, 32'h0000_0002);
    // A wrong entry must relock the settings
    wr(`PLT_OFS_UNLOCK, 32'h0000_0000);
    wr(`PLT_OFS_LIMIT, 32'h0000_0005);
    rdc(`PLT_OFS_LIMIT, 32'h0000_0002);
    check(32'(config_unlocked), 32'h0);
    wr(`PLT_OFS_UNLOCK, 32'h0000_270F);
    rdc(`PLT_OFS_UNLOCK, 32'h0000_0001);
    wr(`PLT_OFS_IRQ_STAT, 32'h0000_0002);
    wr(`PLT_OFS_IRQ_MASK, 32'h0000_0001);
    rdc(`PLT_OFS_IRQ_STAT, 32'h0000_0000);
    // Starve the link right after a telegram, limit is two seconds
    foreach (act_rows[i]) begin
      wr(`PLT_OFS_CTRL, {25'h0, act_rows[i].act, 2'h0, act_rows[i].mode});
      @(posedge hclk iff telegram_ok);
      panel_en <= 1'b0;
      repeat (2 * SEC - 4) @(posedge hclk);
      check(32'(acts), 32'h0);
      repeat (10) @(posedge hclk);
      check(32'(acts), 32'(act_rows[i].e));
      rdc(`PLT_OFS_STATUS, 32'(act_rows[i].e));
      rdc(`PLT_OFS_COUNT, 32'h0000_0402);
      if (act_rows[i].mode != PLT_MODE_OFF) check(32'(irq), 32'h1);
      panel_en <= 1'b1;
      repeat (2 * SEC) @(posedge hclk);
      check(32'(acts), 32'h0);
      rdc(`PLT_OFS_IRQ_STAT, 32'h0000_0005);
      wr(`PLT_OFS_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge hclk);
      check(32'(irq), 32'h0);
    end
    motor_running <= 1'b1;
    wr(`PLT_OFS_CTRL, 32'h0000_0001);
    rdc(`PLT_OFS_CTRL, 32'h0000_0042);
    motor_running <= 1'b0;
    wr(`PLT_OFS_CTRL, 32'h0000_0001);
    rdc(`PLT_OFS_CTRL, 32'h0000_0001);
    // Reset in mid-run must bring every setting back to its default
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`PLT_OFS_CTRL, 32'h0000_0012);
    rdc(`PLT_OFS_LIMIT, 32'h0000_0003);
    rdc(`PLT_OFS_PANEL, 32'h0000_100A);
    results();
  end

  // The whole sequence needs roughly 8.5 us; a hang is cut well after that
  initial begin
    #100us;
    fails++;
    results();
  end
endmodule
